/* adc_parallel_host_port_tb.sv */
// Self-checking bench for the parallel host port.
`timescale 1ns/10ps
`include "adcphp_defs.svh"

module adc_parallel_host_port_tb;
  logic       clk_sys;
  logic       reset;
  logic       cs_n;
  logic       wr_n;
  logic       rd_n;
  logic       hbs;
  logic       clk_pin;
  logic [7:0] bus_drv;
  logic [7:0] bus_wire;
  logic [7:0] dout;
  logic       oe_n;
  logic       done_n;
  logic       done_oe_n;
  logic       conv;
  logic [9:0] sar;
  logic [7:0] ctrl;
  int         error_cnt;
  int         tests_run;
  int         cyc;

  // The bus shows the device only while it drives, otherwise the host's level.
  assign bus_wire = oe_n ? bus_drv : dout;

  adcphp_host_port i_dut
  (
    .clk_sys             (clk_sys),
    .reset               (reset),
    .chip_select_n       (cs_n),
    .write_strobe_n      (wr_n),
    .read_strobe_n       (rd_n),
    .high_byte_select    (hbs),
    .clk_pin             (clk_pin),
    .data_bus_lines_in   (bus_wire),
    .sar_result          (sar),
    .data_bus_lines_out  (dout),
    .data_bus_lines_oe_n (oe_n),
    .done_n_out          (done_n),
    .done_n_oe_n         (done_oe_n),
    .ctrl_byte_out       (ctrl),
    .converting_out      (conv)
  );

  adcphp_host_model host
  (
    .clk_sys          (clk_sys),
    .bus_wire         (bus_wire),
    .chip_select_n    (cs_n),
    .write_strobe_n   (wr_n),
    .read_strobe_n    (rd_n),
    .high_byte_select (hbs),
    .clk_pin          (clk_pin),
    .bus_drv          (bus_drv)
  );

  task automatic final_report;
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      error_cnt++;
    end
  endtask

  // Bounded wait for conversion start (sel 1) or completion (sel 0).
  task automatic wait_for(input logic sel, input int bound);
    int n;
    n = 0;
    while ((sel ? conv !== 1'b1 : done_n !== 1'b0) && n < bound)
    begin
      host.step(1);
      n++;
    end
    chk(10'(n >= bound), 10'h000);
  endtask

  task automatic t_timed(input logic [9:0] pat);
    logic [7:0] d;
    sar = pat;
    host.write_ctrl(8'h00);
    wait_for(1'b1, 60);
    wait_for(1'b0, 120);
    host.read_byte(1'b0, d);
    chk(10'(d), {2'b00, pat[7:0]});
    chk(10'(done_n), 10'h001);
    host.read_byte(1'b1, d);
    chk(10'(d), {8'h00, pat[9:8]});
    host.step(4);
    chk({8'h00, oe_n, done_oe_n}, 10'h003);
  endtask

  task automatic t_ext_acq;
    host.write_ctrl(8'h20);
    chk(10'(ctrl), 10'h020);
    host.step(40);
    chk({8'h00, conv, done_n}, 10'h001);
    host.write_ctrl(8'h00);
    wait_for(1'b1, 4);
  endtask

  task automatic t_ext_clk(input logic [9:0] pat);
    logic [7:0] d;
    sar = pat;
    host.write_ctrl(8'hE0);
    host.write_ctrl(8'hC0);
    chk(10'(ctrl), 10'h0C0);
    wait_for(1'b1, 4);
    host.clk_pulses(12);
    host.step(4);
    chk(10'(done_n), 10'h001);
    host.clk_pulses(1);
    host.step(4);
    chk(10'(done_n), 10'h000);
    host.read_byte(1'b1, d);
    chk(10'(d), {8'h00, pat[9:8]});
  endtask

  // A second write mid-conversion must restart from acquisition.
  task automatic t_abort(input logic [9:0] pat);
    logic [7:0] d;
    sar = pat;
    host.write_ctrl(8'h00);
    wait_for(1'b1, 60);
    host.write_ctrl(8'h00);
    chk({8'h00, conv, done_n}, 10'h001);
    wait_for(1'b1, 60);
    wait_for(1'b0, 120);
    host.write_ctrl(8'h20);
    chk({8'h00, conv, done_n}, 10'h001);
    host.read_byte(1'b0, d);
    chk(10'(d), {2'b00, pat[7:0]});
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      final_report();
    end
  end

  initial
  begin
    error_cnt = 0;
    tests_run = 0;
    cyc = 0;
    reset = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    host.step(3);
    t_timed(10'h2A5);
    t_ext_acq();
    t_ext_clk(10'h16C);
    t_abort(10'h1B3);
    final_report();
  end
endmodule

/* adcphp_defs.svh */
// Constants for the parallel host port of the 10-bit converter.
// Summary of operation
// - The 10-bit result is read in two parts, the two top bits when high_byte_select is 1 and the eight low bits when it is 0.
// - The two lowest data lines carry result bits 1 and 0 with high_byte_select low and bits 9 and 8 with it high.
// - The active-low completion flag goes low once a conversion has finished and its result is ready.
// - A read is a falling read strobe with chip select low, and the device then drives its result onto the data lines.
// - In internal acquisition mode a rising write strobe with chip select low latches the control byte and starts a timed acquisition followed by a conversion.
// - In external acquisition mode the next rising write strobe with chip select low ends acquisition and starts the conversion;
//   the code does so only when that write has the acquisition-mode bit at 0, and a write with it at 1 restarts acquisition.
// - In external clock mode the conversion is timed from the free-running clock pin, otherwise from an internal oscillator while the pin sits at a fixed level.
// - While chip select is high the completion flag and all eight data lines float.
// - The completion flag returns high on the first read after it went low and whenever a new control byte is written.
// - Every conversion takes 13 conversion clock cycles in every clock and acquisition mode.
// - A control byte written during a conversion abandons it and starts a fresh acquisition.
// - The acquisition-mode bit at 0 selects timed acquisition, and external acquisition takes a write with it at 1 then a write with it at 0.
`ifndef ADCPHP_DEFS_SVH
`define ADCPHP_DEFS_SVH

`define ADCPHP_RES_W        10
`define ADCPHP_BUS_W        8
`define ADCPHP_CLKMODE_HI   7
`define ADCPHP_CLKMODE_LO   6
`define ADCPHP_CLKMODE_EXT  2'h3
`define ADCPHP_ACQMODE_BIT  5
`define ADCPHP_CONV_CYCLES  4'hD
`define ADCPHP_ACQ_CYCLES   4'h3
`define ADCPHP_INT_CLK_DIV  3'h6
`define ADCPHP_CTRL_RESET   8'h00
`define ADCPHP_RES_RESET    10'h000

`endif

/* adcphp_host_model.sv */
// Microprocessor bus model that drives the converter's host pins.
`timescale 1ns/10ps

module adcphp_host_model
(
  input  wire logic       clk_sys,
  input  wire logic [7:0] bus_wire,
  output logic            chip_select_n,
  output logic            write_strobe_n,
  output logic            read_strobe_n,
  output logic            high_byte_select,
  output logic            clk_pin,
  output logic [7:0]      bus_drv
);
  initial
  begin
    chip_select_n = 1'b1;
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    high_byte_select = 1'b0;
    clk_pin = 1'b0;
    bus_drv = 8'hFF;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic write_ctrl(input logic [7:0] b);
    chip_select_n = 1'b0;
    bus_drv = b;
    write_strobe_n = 1'b0;
    step(4);
    write_strobe_n = 1'b1;
    step(2);
    chip_select_n = 1'b1;
    bus_drv = ~b;
    step(1);
  endtask

  // read strobe falls with select low
  task automatic read_byte(input logic hi, output logic [7:0] d);
    chip_select_n = 1'b0;
    high_byte_select = hi;
    read_strobe_n = 1'b0;
    step(5);
    d = bus_wire;
    read_strobe_n = 1'b1;
    chip_select_n = 1'b1;
    step(1);
  endtask

  // clock pin rests low between bursts
  task automatic clk_pulses(input int n);
    repeat (n)
    begin
      clk_pin = 1'b1;
      step(4);
      clk_pin = 1'b0;
      step(4);
    end
  endtask
endmodule

/* adcphp_host_port.sv */
// Parallel host port: control byte capture, acquisition, conversion timing, result read.
`timescale 1ns/10ps
`include "adcphp_defs.svh"

module adcphp_host_port
  import adcphp_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     reset,
  input  wire logic                     chip_select_n,
  input  wire logic                     write_strobe_n,
  input  wire logic                     read_strobe_n,
  input  wire logic                     high_byte_select,
  input  wire logic                     clk_pin,
  input  wire logic [`ADCPHP_BUS_W-1:0] data_bus_lines_in,
  input  wire logic [`ADCPHP_RES_W-1:0] sar_result,
  output logic      [`ADCPHP_BUS_W-1:0] data_bus_lines_out,
  output logic                          data_bus_lines_oe_n,
  output logic                          done_n_out,
  output logic                          done_n_oe_n,
  output logic      [`ADCPHP_BUS_W-1:0] ctrl_byte_out,
  output logic                          converting_out
);

  // Pin synchronisers: first stage is read only by the second.
  logic [11:0] pin_meta_r;
  logic [11:0] pin_sync_r;
  logic        wr_prev_r;
  logic        rd_prev_r;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pin_meta_r <= 12'hF00;
      pin_sync_r <= 12'hF00;
    end
    else
    begin
      pin_meta_r <= {chip_select_n, write_strobe_n, read_strobe_n, high_byte_select,
                     data_bus_lines_in};
      pin_sync_r <= pin_meta_r;
    end
  end

  logic                     cs_s;
  logic                     wr_s;
  logic                     rd_s;
  logic                     hbs_s;
  logic [`ADCPHP_BUS_W-1:0] din_s;
  logic                     wr_rise;
  logic                     rd_fall;

  assign cs_s    = pin_sync_r[11];
  assign wr_s    = pin_sync_r[10];
  assign rd_s    = pin_sync_r[9];
  assign hbs_s   = pin_sync_r[8];
  assign din_s   = pin_sync_r[7:0];
  assign wr_rise = !wr_prev_r && wr_s && !cs_s;
  assign rd_fall = rd_prev_r && !rd_s && !cs_s;

  logic                     conv_tick;
  adcphp_state_t            state_r;
  adcphp_state_t            state_nxt;
  logic [3:0]               cnt_r;
  logic [3:0]               cnt_nxt;
  logic [`ADCPHP_BUS_W-1:0] ctrl_r;
  logic [`ADCPHP_BUS_W-1:0] ctrl_nxt;
  logic [`ADCPHP_RES_W-1:0] result_r;
  logic [`ADCPHP_RES_W-1:0] result_nxt;
  logic                     done_r;
  logic                     done_nxt;
  logic                     conv_end;

  // The clock mode in force is the one latched from the last control byte.
  adcphp_tick u_tick
  (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .clk_pin      (clk_pin),
    .ext_clk_mode (ctrl_r[`ADCPHP_CLKMODE_HI:`ADCPHP_CLKMODE_LO] == `ADCPHP_CLKMODE_EXT),
    .conv_tick_r  (conv_tick)
  );

  assign conv_end = (state_r == ADCPHP_CONV) && conv_tick && (cnt_r == `ADCPHP_CONV_CYCLES - 4'h1);

  always_comb
  begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    ctrl_nxt   = ctrl_r;
    result_nxt = result_r;
    done_nxt   = done_r;
    if (rd_fall)
    begin
      done_nxt = 1'b0;
    end
    if (wr_rise)
    begin
      ctrl_nxt = din_s;
      cnt_nxt  = 4'h0;
      done_nxt = 1'b0;
      if (din_s[`ADCPHP_ACQMODE_BIT])
      begin
        state_nxt = ADCPHP_ACQ_EXT;
      end
      else if (state_r == ADCPHP_ACQ_EXT)
      begin
        state_nxt = ADCPHP_CONV;
      end
      else
      begin
        state_nxt = ADCPHP_ACQ_INT;
      end
    end
    else if (conv_tick)
    begin
      case (state_r)
        ADCPHP_ACQ_INT:
        begin
          if (cnt_r == `ADCPHP_ACQ_CYCLES - 4'h1)
          begin
            state_nxt = ADCPHP_CONV;
            cnt_nxt   = 4'h0;
          end
          else
          begin
            cnt_nxt = cnt_r + 4'h1;
          end
        end
        ADCPHP_CONV:
        begin
          if (conv_end)
          begin
            state_nxt  = ADCPHP_IDLE;
            cnt_nxt    = 4'h0;
            result_nxt = sar_result;
            done_nxt   = 1'b1;
          end
          else
          begin
            cnt_nxt = cnt_r + 4'h1;
          end
        end
        default:
        begin
          cnt_nxt = 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_r   <= ADCPHP_IDLE;
      cnt_r     <= 4'h0;
      ctrl_r    <= `ADCPHP_CTRL_RESET;
      result_r  <= `ADCPHP_RES_RESET;
      done_r    <= 1'b0;
      wr_prev_r <= 1'b1;
      rd_prev_r <= 1'b1;
    end
    else
    begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      ctrl_r    <= ctrl_nxt;
      result_r  <= result_nxt;
      done_r    <= done_nxt;
      wr_prev_r <= wr_s;
      rd_prev_r <= rd_s;
    end
  end

  // Output stage, all registered.
  logic [`ADCPHP_BUS_W-1:0] dout_nxt;

  always_comb
  begin
    dout_nxt = hbs_s ? {6'h00, result_r[9:8]} : result_r[7:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      data_bus_lines_out  <= 8'h00;
      data_bus_lines_oe_n <= 1'b1;
      done_n_out          <= 1'b1;
      done_n_oe_n         <= 1'b1;
      ctrl_byte_out       <= `ADCPHP_CTRL_RESET;
      converting_out      <= 1'b0;
    end
    else
    begin
      data_bus_lines_out  <= dout_nxt;
      data_bus_lines_oe_n <= cs_s || rd_s;
      done_n_out          <= !done_nxt;
      done_n_oe_n         <= cs_s;
      ctrl_byte_out       <= ctrl_nxt;
      converting_out      <= (state_nxt == ADCPHP_CONV);
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  a_low_byte_read: assert property ((!data_bus_lines_oe_n && !$past(hbs_s)) |->
    data_bus_lines_out == $past(result_r[7:0])) else $error("Low byte lane wrong.");
  a_high_byte_read: assert property ((!data_bus_lines_oe_n && $past(hbs_s)) |->
    data_bus_lines_out == {6'h00, $past(result_r[9:8])}) else $error("High byte lane wrong.");
  a_flag_on_done: assert property (conv_end |=> !done_n_out [*2] or (!done_n_out ##1 done_n_out))
    else $error("Completion flag not low after conversion.");
  a_read_enables_bus: assert property ((!cs_s && !rd_s) |=> !data_bus_lines_oe_n)
    else $error("Bus not driven during read.");
  a_int_acq_start: assert property ((wr_rise && !din_s[5] && state_r != ADCPHP_ACQ_EXT) |=>
    state_r == ADCPHP_ACQ_INT && cnt_r == 4'h0) else $error("Timed acquisition not started.");
  a_ext_acq_end: assert property ((wr_rise && !din_s[5] && state_r == ADCPHP_ACQ_EXT) |=>
    state_r == ADCPHP_CONV) else $error("Conversion not started by second write.");
  a_float_deselect: assert property (cs_s |=> (data_bus_lines_oe_n && done_n_oe_n))
    else $error("Outputs driven while deselected.");
  a_read_clears_flag: assert property ((rd_fall && !conv_end) |=> done_n_out)
    else $error("Completion flag not cleared by read.");
  a_conv_length: assert property ((state_r == ADCPHP_CONV && conv_tick && !wr_rise) |=>
    (cnt_r == $past(cnt_r) + 4'h1 || (state_r == ADCPHP_IDLE && $past(cnt_r) == 4'hC)))
    else $error("Conversion cycle count wrong.");
  a_write_aborts: assert property ((wr_rise && state_r == ADCPHP_CONV) |=>
    state_r != ADCPHP_CONV && done_n_out) else $error("Write did not abort conversion.");

endmodule

/* adcphp_pkg.sv */
// Types shared by the parallel host port files.
package adcphp_pkg;

  typedef enum logic [1:0]
  {
    ADCPHP_IDLE    = 2'b00,
    ADCPHP_ACQ_INT = 2'b01,
    ADCPHP_ACQ_EXT = 2'b10,
    ADCPHP_CONV    = 2'b11
  } adcphp_state_t;

endpackage

/* adcphp_tick.sv */
// Conversion clock enable from the clock pin or from an internal divider.
`timescale 1ns/10ps
`include "adcphp_defs.svh"

module adcphp_tick
  import adcphp_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic clk_pin,
  input  wire logic ext_clk_mode,
  output logic      conv_tick_r
);

  logic       pin_meta_r;
  logic       pin_sync_r;
  logic       pin_prev_r;
  logic [2:0] div_r;
  logic [2:0] div_nxt;
  logic       tick_nxt;

  // The pin is foreign to clk_sys, so only the second stage feeds the edge test.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
    end
    else
    begin
      pin_meta_r <= clk_pin;
      pin_sync_r <= pin_meta_r;
    end
  end

  always_comb
  begin
    div_nxt  = (div_r == `ADCPHP_INT_CLK_DIV - 3'h1) ? 3'h0 : div_r + 3'h1;
    tick_nxt = ext_clk_mode ? (pin_prev_r && !pin_sync_r) : (div_r == 3'h0);
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pin_prev_r  <= 1'b0;
      div_r       <= 3'h0;
      conv_tick_r <= 1'b0;
    end
    else
    begin
      pin_prev_r  <= pin_sync_r;
      div_r       <= div_nxt;
      conv_tick_r <= tick_nxt;
    end
  end

  a_pin_tick_source: assert property (@(posedge clk_sys) disable iff (reset)
    $past(ext_clk_mode) |-> conv_tick_r == $past(pin_prev_r && !pin_sync_r))
    else $error("Conversion tick not taken from clock pin.");

endmodule
